// ---- pkg/tbt_pkg.sv ----
package tbt_pkg;

	// Counter geometry
	localparam int CNT_W = 21;
	localparam int CNT_DIV_LOG2 = 1;

	// Register bus
	localparam int BUS_DW = 32;
	localparam int BUS_BEW = 4;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
	localparam logic [BUS_DW-1:0] UNMAPPED_READ = 32'h00000000;

	// Control/status register layout
	localparam int REG_W = 8;
	localparam int FLAG_BIT = 7;
	localparam int IE_BIT = 6;
	localparam int SEL_HI_BIT = 2;
	localparam int SEL_LO_BIT = 1;
	localparam int CLR_BIT = 0;
	localparam int BE_LANE = 0;
	localparam logic FLAG_RESET = 1'h0;
	localparam logic IE_RESET = 1'h0;
	localparam logic [1:0] SEL_RESET = 2'h0;
	localparam logic CLR_READ = 1'h1;
	localparam logic [2:0] UNUSED_READ = 3'h0;

	// Interval select codes, shortest to longest
	localparam logic [1:0] SEL_INT0 = 2'h0;
	localparam logic [1:0] SEL_INT1 = 2'h1;
	localparam logic [1:0] SEL_INT2 = 2'h2;
	localparam logic [1:0] SEL_INT3 = 2'h3;

	// Stabilization wait select codes
	localparam logic [1:0] WAIT_SEL_A = 2'h1;
	localparam logic [1:0] WAIT_SEL_B = 2'h2;
	localparam logic [1:0] WAIT_SEL_C = 2'h3;

	// Periods as powers of two of the oscillator period
	localparam int INT0_EXP = 13;
	localparam int INT1_EXP = 15;
	localparam int INT2_EXP = 18;
	localparam int INT3_EXP = 22;
	localparam int WAIT_A_EXP = 14;
	localparam int WAIT_B_EXP = 17;
	localparam int WAIT_C_EXP = 18;
	localparam int WDT_CLK_EXP = 21;
	localparam int LCD_CLK_EXP = 8;
	localparam int ADC_CLK_EXP = 10;

	// Overflowing bit n marks 2^(n+1) counts, i.e. 2^(n+2) oscillator periods
	localparam int OVF_OFS = CNT_DIV_LOG2 + 1;
	// A clock taken from bit n has a period of 2^(n+2) oscillator periods
	localparam int CLK_OFS = CNT_DIV_LOG2 + 1;

	typedef enum logic [1:0] {
		TBT_HALT,
		TBT_WAIT,
		TBT_RUN
	} tbt_mode_t;

endpackage : tbt_pkg

// ---- pkg/tbt_cnt_if.sv ----
`timescale 1ns/1ps
interface tbt_cnt_if;
	import tbt_pkg::*;

	logic clear;
	logic run;
	logic step;
	logic [CNT_W-1:0] count;

	modport ctl (
		output clear,
		output run,
		input step,
		input count
	);

	modport cnt (
		input clear,
		input run,
		output step,
		output count
	);

endinterface : tbt_cnt_if

// ---- hdl/tbt_counter.sv ----
`timescale 1ns/1ps
module tbt_counter
	import tbt_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Counter control and value
	tbt_cnt_if.cnt cif
);

	typedef struct packed {
		logic phase;
		logic [CNT_W-1:0] count;
	} tbt_cnt_state_t;

	tbt_cnt_state_t state_q;
	tbt_cnt_state_t state_d;

	// Count clock is every second system clock edge
	assign cif.step = state_q.phase & cif.run & ~cif.clear;
	assign cif.count = state_q.count;

	always_comb begin
		state_d = state_q;
		if (cif.clear) begin
			// A clear also restarts the divide-by-two phase
			state_d.phase = 1'b0;
			state_d.count = '0;
		end else if (cif.run) begin
			state_d.phase = ~state_q.phase;
			if (state_q.phase) begin
				state_d.count = state_q.count + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

endmodule : tbt_counter

// ---- hdl/tbt_top.sv ----
`timescale 1ns/1ps
module tbt_top
	import tbt_pkg::*;
#(
	parameter int ADC_EXP = ADC_CLK_EXP
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,

	// Avalon-MM slave
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [BUS_DW-1:0] avs_writedata,
	input wire logic [BUS_BEW-1:0] avs_byteenable,
	output logic [BUS_DW-1:0] avs_readdata,
	output logic avs_waitrequest,

	// Clock controller
	input wire logic main_stop_mode,
	input wire logic subclock_mode,
	input wire logic [1:0] stabilization_wait_select,
	output logic osc_stable,

	// Watchdog
	input wire logic watchdog_cs_timebase,
	output logic watchdog_clear,
	output logic watchdog_clk,

	// Peripheral clocks
	output logic adc_clk,
	output logic lcd_clk,

	// Interrupt to the CPU
	output logic timebase_irq_line
);

	// Counter bit whose overflow marks each interval
	localparam int TAP_INT0 = INT0_EXP - OVF_OFS;
	localparam int TAP_INT1 = INT1_EXP - OVF_OFS;
	localparam int TAP_INT2 = INT2_EXP - OVF_OFS;
	localparam int TAP_INT3 = INT3_EXP - OVF_OFS;

	// Counter bit whose overflow ends each stabilization wait
	localparam int TAP_WAIT_A = WAIT_A_EXP - OVF_OFS;
	localparam int TAP_WAIT_B = WAIT_B_EXP - OVF_OFS;
	localparam int TAP_WAIT_C = WAIT_C_EXP - OVF_OFS;

	// Counter bits driven out as divided clocks
	localparam int TAP_WDT = WDT_CLK_EXP - CLK_OFS;
	localparam int TAP_LCD = LCD_CLK_EXP - CLK_OFS;
	localparam int TAP_ADC = ADC_EXP - CLK_OFS;

	typedef struct packed {
		tbt_mode_t mode;
		logic flag;
		logic ie;
		logic [1:0] sel;
		logic irq;
		logic stable;
		logic wrq;
		logic [BUS_DW-1:0] rdata;
		logic wdt_clr;
		logic wdt_clk;
		logic adc_clk;
		logic lcd_clk;
	} tbt_top_state_t;

	tbt_top_state_t state_q;
	tbt_top_state_t state_d;

	tbt_cnt_if cif ();

	tbt_counter u_counter (
		.sys_clk(sys_clk),
		.rst(rst),
		.cif(cif)
	);

	// True when bits tap..0 are all ones, so the next step carries out of tap
	function automatic logic tap_full(
		input logic [CNT_W-1:0] c,
		input int tap
	);
		logic r;
		r = 1'b1;
		for (int i = 0; i < CNT_W; i++) begin
			if (i <= tap && !c[i]) begin
				r = 1'b0;
			end
		end
		return r;
	endfunction : tap_full

	// Interval bit for a select code, shortest first
	function automatic int interval_tap(
		input logic [1:0] code
	);
		int t;
		t = TAP_INT0;
		case (code)
			SEL_INT0: t = TAP_INT0;
			SEL_INT1: t = TAP_INT1;
			SEL_INT2: t = TAP_INT2;
			SEL_INT3: t = TAP_INT3;
			default: t = TAP_INT0;
		endcase
		return t;
	endfunction : interval_tap

	// Stabilization wait bit; the unused code falls back to the shortest wait
	function automatic int wait_tap(
		input logic [1:0] code
	);
		int t;
		t = TAP_WAIT_A;
		case (code)
			WAIT_SEL_A: t = TAP_WAIT_A;
			WAIT_SEL_B: t = TAP_WAIT_B;
			WAIT_SEL_C: t = TAP_WAIT_C;
			default: t = TAP_WAIT_A;
		endcase
		return t;
	endfunction : wait_tap

	// Register image as software sees it
	function automatic logic [REG_W-1:0] reg_image(
		input tbt_top_state_t s
	);
		logic [REG_W-1:0] v;
		v = '0;
		v[FLAG_BIT] = s.flag;
		v[IE_BIT] = s.ie;
		v[IE_BIT-1:SEL_HI_BIT+1] = UNUSED_READ;
		v[SEL_HI_BIT:SEL_LO_BIT] = s.sel;
		v[CLR_BIT] = CLR_READ;
		return v;
	endfunction : reg_image

	logic osc_off;
	logic hit;
	logic wr_now;
	logic sw_clear;
	logic any_clear;
	logic int_ovf;
	logic wait_ovf;

	// Oscillator is stopped in either low-power mode
	assign osc_off = main_stop_mode | subclock_mode;

	assign hit = (avs_address == CTRL_OFFSET);

	// A write lands on the edge where waitrequest is seen low
	assign wr_now = avs_write & ~state_q.wrq & hit & avs_byteenable[BE_LANE];

	assign sw_clear = wr_now & ~avs_writedata[CLR_BIT];

	// Mode entry clears and keeps clearing while the oscillator is off
	assign any_clear = sw_clear | osc_off;

	assign cif.clear = any_clear;
	assign cif.run = ~osc_off;

	// An overflow that meets a clear is dropped
	assign int_ovf = cif.step & tap_full(cif.count, interval_tap(state_q.sel)) & ~any_clear;

	assign wait_ovf = cif.step & tap_full(cif.count, wait_tap(stabilization_wait_select)) & ~any_clear;

	always_comb begin
		state_d = state_q;

		// Bus handshake: one wait cycle, then a single cycle with waitrequest low
		if (state_q.wrq) begin
			if (avs_read || avs_write) begin
				state_d.wrq = 1'b0;
				if (avs_read && hit) begin
					state_d.rdata = {{(BUS_DW-REG_W){1'b0}}, reg_image(state_q)};
				end else begin
					state_d.rdata = UNMAPPED_READ;
				end
			end
		end else begin
			state_d.wrq = 1'b1;
		end

		// Software writes to the control fields
		if (wr_now) begin
			state_d.ie = avs_writedata[IE_BIT];
			state_d.sel = avs_writedata[SEL_HI_BIT:SEL_LO_BIT];
			if (!avs_writedata[FLAG_BIT]) begin
				state_d.flag = 1'b0;
			end
		end

		// Hardware set wins over a software clear in the same cycle
		if (int_ovf) begin
			state_d.flag = 1'b1;
		end

		// Request follows the next flag and enable, so enabling over a set flag fires at once
		state_d.irq = state_d.flag & state_d.ie;

		// Oscillator mode tracking
		case (state_q.mode)
			TBT_RUN: begin
				if (osc_off) begin
					state_d.mode = TBT_HALT;
					state_d.stable = 1'b0;
				end
			end
			TBT_HALT: begin
				if (!osc_off) begin
					state_d.mode = TBT_WAIT;
				end
			end
			TBT_WAIT: begin
				if (osc_off) begin
					state_d.mode = TBT_HALT;
				end else if (wait_ovf) begin
					state_d.mode = TBT_RUN;
					state_d.stable = 1'b1;
				end
			end
			default: begin
				state_d.mode = TBT_HALT;
				state_d.stable = 1'b0;
			end
		endcase

		// Watchdog follows every clear when it counts this clock
		state_d.wdt_clr = any_clear & watchdog_cs_timebase;

		// Divided clocks; a clear drops them back to their initial low phase
		state_d.wdt_clk = cif.count[TAP_WDT];
		state_d.adc_clk = cif.count[TAP_ADC];
		state_d.lcd_clk = cif.count[TAP_LCD];
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			// Power-on: oscillator just started, so the wait must be counted
			state_q.mode <= TBT_WAIT;
			state_q.flag <= FLAG_RESET;
			state_q.ie <= IE_RESET;
			state_q.sel <= SEL_RESET;
			state_q.irq <= 1'b0;
			state_q.stable <= 1'b0;
			state_q.wrq <= 1'b1;
			state_q.rdata <= UNMAPPED_READ;
			state_q.wdt_clr <= 1'b0;
			state_q.wdt_clk <= 1'b0;
			state_q.adc_clk <= 1'b0;
			state_q.lcd_clk <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	assign avs_readdata = state_q.rdata;
	assign avs_waitrequest = state_q.wrq;
	assign osc_stable = state_q.stable;
	assign watchdog_clear = state_q.wdt_clr;
	assign watchdog_clk = state_q.wdt_clk;
	assign adc_clk = state_q.adc_clk;
	assign lcd_clk = state_q.lcd_clk;
	assign timebase_irq_line = state_q.irq;

endmodule : tbt_top

// ---- bench/tbt_top_monitor.sv ----
`timescale 1ns/1ps
module tbt_top_monitor
	import tbt_pkg::*;
#(
	parameter int ADC_EXP = ADC_CLK_EXP
) (
	// Clock, reset and bus
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [BUS_DW-1:0] avs_writedata,
	input wire logic [BUS_BEW-1:0] avs_byteenable,
	input wire logic [BUS_DW-1:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Modes and outputs
	input wire logic main_stop_mode,
	input wire logic subclock_mode,
	input wire logic osc_stable,
	input wire logic watchdog_cs_timebase,
	input wire logic watchdog_clear,
	input wire logic watchdog_clk,
	input wire logic adc_clk,
	input wire logic lcd_clk,
	input wire logic timebase_irq_line
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic rd_ack, wr_ack, stop;
	assign rd_ack = avs_read && !avs_waitrequest && avs_address == CTRL_OFFSET;
	assign wr_ack = avs_write && !avs_waitrequest && avs_address == CTRL_OFFSET && avs_byteenable[BE_LANE];
	assign stop = main_stop_mode || subclock_mode;
	a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not a single cycle");
	a_read_layout: assert property (rd_ack |-> avs_readdata[CLR_BIT] && avs_readdata[31:8] == 24'h0)
		else $error("fixed read bits wrong");
	a_irq_is_and: assert property (rd_ack |-> (avs_readdata[FLAG_BIT] && avs_readdata[IE_BIT]) == $past(timebase_irq_line))
		else $error("irq differs from flag and enable");
	a_disable_drops: assert property (wr_ack && !avs_writedata[IE_BIT] |=> !timebase_irq_line)
		else $error("irq stays after disable");
	a_flag_wr0: assert property (wr_ack && !avs_writedata[FLAG_BIT] |=> !timebase_irq_line)
		else $error("irq stays after flag write 0");
	a_wdog_follow: assert property (wr_ack && !avs_writedata[CLR_BIT] && watchdog_cs_timebase |=> ##[0:1] watchdog_clear)
		else $error("watchdog not cleared with counter");
	a_wdog_gate: assert property (!watchdog_cs_timebase && !$past(watchdog_cs_timebase) |-> !watchdog_clear)
		else $error("watchdog cleared while not selected");
	a_stop_clears: assert property (stop |=> !osc_stable)
		else $error("stable flag kept in stop");
	a_stop_halts: assert property (stop [*3] |-> !lcd_clk && !adc_clk && !watchdog_clk)
		else $error("clocks run while stopped");
	a_wait_min: assert property ($fell(stop) |-> !osc_stable [*8])
		else $error("stable flag too early");
	c_read: cover property (rd_ack);
	c_clear: cover property (wr_ack && !avs_writedata[CLR_BIT]);
	c_stable: cover property ($rose(osc_stable));
	c_irq: cover property (timebase_irq_line);
endmodule : tbt_top_monitor

bind tbt_top tbt_top_monitor #(.ADC_EXP(ADC_EXP)) u_mon (.sys_clk(sys_clk), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.main_stop_mode(main_stop_mode), .subclock_mode(subclock_mode), .osc_stable(osc_stable),
	.watchdog_cs_timebase(watchdog_cs_timebase), .watchdog_clear(watchdog_clear), .watchdog_clk(watchdog_clk),
	.adc_clk(adc_clk), .lcd_clk(lcd_clk), .timebase_irq_line(timebase_irq_line));

// ---- bench/tbt_top_tb.sv ----
`timescale 1ns/1ps
module tbt_top_tb;
	import tbt_pkg::*;
	typedef struct {logic [3:0] a; logic [3:0] be; logic [7:0] d; logic [7:0] exp;} tbt_row_t;
	logic sys_clk = 1'h0;
	logic rst = 1'h1;
	logic [ADDR_W-1:0] avs_address = 4'h0;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [BUS_DW-1:0] avs_writedata = 32'h0;
	logic [BUS_BEW-1:0] avs_byteenable = 4'hF;
	logic main_stop_mode = 1'h0;
	logic subclock_mode = 1'h0;
	logic [1:0] stabilization_wait_select = 2'h1;
	logic watchdog_cs_timebase = 1'h1;
	logic [BUS_DW-1:0] avs_readdata;
	logic avs_waitrequest, osc_stable, watchdog_clear, watchdog_clk, adc_clk, lcd_clk, timebase_irq_line;
	logic [31:0] q;
	logic seen;
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;
	int t0;
	// Writes to unmapped places, lane 0 off or unused bits must leave the image alone
	tbt_row_t rows [6] = '{'{4'h0, 4'hF, 8'h3F, 8'h07}, '{4'h0, 4'hF, 8'h7B, 8'h43}, '{4'h4, 4'hF, 8'h05, 8'h43},
		'{4'h0, 4'hE, 8'h05, 8'h43}, '{4'h0, 4'hF, 8'h85, 8'h05}, '{4'h0, 4'hF, 8'h01, 8'h01}};

	tbt_top u_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .main_stop_mode(main_stop_mode),
		.subclock_mode(subclock_mode), .stabilization_wait_select(stabilization_wait_select),
		.osc_stable(osc_stable), .watchdog_cs_timebase(watchdog_cs_timebase), .watchdog_clear(watchdog_clear),
		.watchdog_clk(watchdog_clk), .adc_clk(adc_clk), .lcd_clk(lcd_clk), .timebase_irq_line(timebase_irq_line));

	always #2.5 sys_clk = ~sys_clk;

	task automatic end_sim;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_win(input int got, input int lo, input int hi);
		n_compared++;
		if (got < lo || got > hi) begin
			errors++;
			$display("unexpected at %0t: got %h, expected %h to %h", $time, got, lo, hi);
		end
	endtask : chk_win

	// Entered just after a rising edge; leaves one idle edge so requests never merge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [3:0] be, input logic [7:0] d);
		avs_address <= a;
		avs_byteenable <= be;
		avs_writedata <= {24'h0, d};
		avs_write <= wr;
		avs_read <= !wr;
		// Only the cycle ceiling ends a wait that never answers
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'h0);
		q = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		@(posedge sys_clk);
	endtask : bus

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 80000) begin
			errors++;
			end_sim();
		end
	end

	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'h0;
		@(posedge sys_clk);
		bus(0, 4'h0, 4'hF, 8'h0);
		chk(q, 32'h01);
		foreach (rows[i]) begin
			bus(1, rows[i].a, rows[i].be, rows[i].d);
			bus(0, 4'h0, 4'hF, 8'h0);
			chk(q, {24'h0, rows[i].exp});
		end
		bus(0, 4'h4, 4'hF, 8'h0);
		chk(q, UNMAPPED_READ);
		$display("register image done");
		for (int s = 0; s < 2; s++) begin
			watchdog_cs_timebase <= !s[0];
			bus(1, 4'h0, 4'hF, {5'h0, s[1:0], 1'h0});
			t0 = cyc;
			seen = 1'h0;
			repeat (3) begin
				seen |= watchdog_clear;
				@(posedge sys_clk);
			end
			chk({31'h0, seen}, {31'h0, !s[0]});
			q = 32'h0;
			while (q[FLAG_BIT] !== 1'h1 && cyc - t0 < 40000) bus(0, 4'h0, 4'hF, 8'h0);
			chk_win(cyc - t0, (1 << (13 + 2 * s)) - 4, (1 << (13 + 2 * s)) + 8);
			chk({31'h0, timebase_irq_line}, 32'h0);
		end
		bus(1, 4'h0, 4'hF, 8'hC3);
		chk({31'h0, timebase_irq_line}, 32'h1);
		bus(1, 4'h0, 4'hF, 8'h43);
		chk({31'h0, timebase_irq_line}, 32'h0);
		bus(0, 4'h0, 4'hF, 8'h0);
		chk(q, 32'h43);
		bus(1, 4'h0, 4'hF, 8'h03);
		$display("interval and interrupt done");
		watchdog_cs_timebase <= 1'h1;
		for (int m = 0; m < 2; m++) begin
			main_stop_mode <= !m[0];
			subclock_mode <= m[0];
			repeat (4) @(posedge sys_clk);
			chk({30'h0, osc_stable, watchdog_clear}, 32'h1);
			main_stop_mode <= 1'h0;
			subclock_mode <= 1'h0;
			t0 = cyc;
			@(posedge sys_clk);
		end
		while (osc_stable !== 1'h1 && cyc - t0 < 20000) @(posedge sys_clk);
		chk_win(cyc - t0, 16384 - 4, 16384 + 8);
		bus(1, 4'h0, 4'hF, 8'h02);
		t0 = cyc;
		while (lcd_clk !== 1'h1 && cyc - t0 < 600) @(posedge sys_clk);
		chk_win(cyc - t0, 124, 134);
		$display("modes and clocks done");
		end_sim();
	end
endmodule : tbt_top_tb
